//--- hdl/lai_consts.svh
// Purpose: Constants for the light sensor integration timing and readout block.
// Assumes: Included by bare name after the package.
// Notes: Offsets are register pointer values on the two-wire bus.
//
// Behaviour
// - Command bit 4 chooses internal or external integration timing.
// - Internal timing integrates exactly 2^n oscillator cycles, n from bits 3:2.
// - First sync starts a conversion; each later sync ends it and starts next.
// - External timing counts oscillator cycles between consecutive syncs as the timer value.
// - Command 1xx101xx shows the cycle count in data registers 01h and 02h.
// - Oscillator runs identically in both modes; only cycles per integration differ.
// - Target answers only at fixed 7-bit address 1000100.
// - Write with pointer byte top bit set is a sync, external timing only.
// - Bits 4:3:2 decode 16/12/8/4-bit internal, external result, timer, reserved.
// - Data registers refresh at the end of every conversion.
// - One-time measurement powers the device down after each measurement.
`ifndef LAI_CONSTS_SVH
`define LAI_CONSTS_SVH

`define LAI_DEV_ADDR 7'h44
`define LAI_OFS_CMD 8'h00
`define LAI_OFS_LSB 8'h01
`define LAI_OFS_MSB 8'h02
`define LAI_CMD_RESET 8'h00
`define LAI_DATA_RESET 16'h0000
`define LAI_BIT_EN 7
`define LAI_BIT_CONT 6
`define LAI_BIT_IR 5
`define LAI_BIT_EXT 4
`define LAI_BIT_RES_HI 3
`define LAI_BIT_RES_LO 2
`define LAI_BIT_RANGE_HI 1
`define LAI_BIT_RANGE_LO 0
`define LAI_BIT_SYNC 7
`define LAI_MODE_EXT_RESULT 3'h4
`define LAI_MODE_EXT_TIMER 3'h5
`define LAI_CLK_KHZ 100000
`define LAI_OSC_KHZ 725
`define LAI_OSC_DIV (`LAI_CLK_KHZ / `LAI_OSC_KHZ)

`endif

//--- hdl/lai_pkg.sv
// Purpose: Types and helper functions for the light sensor readout block.
// Assumes: Nothing beyond standard SystemVerilog.
// Notes: State codes are one-hot.
package lai_pkg;

    typedef logic [7:0] lai_byte_t;
    typedef logic [15:0] lai_word_t;

    typedef enum logic [2:0] {
        TS_IDLE = 3'h1,
        TS_WAIT = 3'h2,
        TS_RUN = 3'h4
    } lai_tstate_t;

    typedef enum logic [8:0] {
        BS_IDLE = 9'h001,
        BS_ADDR = 9'h002,
        BS_AACK = 9'h004,
        BS_REG = 9'h008,
        BS_RACK = 9'h010,
        BS_WR = 9'h020,
        BS_WACK = 9'h040,
        BS_RD = 9'h080,
        BS_RDACK = 9'h100
    } lai_bstate_t;

    // Cycles per internal integration for resolution select bits 3:2.
    function automatic logic [16:0] lai_cycles(input logic [1:0] res);
        case (res)
            2'h0: lai_cycles = 17'h10000;
            2'h1: lai_cycles = 17'h01000;
            2'h2: lai_cycles = 17'h00100;
            default: lai_cycles = 17'h00010;
        endcase
    endfunction

    // Limits a count to the full scale of the selected resolution.
    function automatic lai_word_t lai_clip(input lai_word_t val, input logic [1:0] res);
        logic [16:0] top;
        top = lai_cycles(res) - 17'h00001;
        lai_clip = (val > top[15:0]) ? top[15:0] : val;
    endfunction

endpackage

//--- hdl/lai_timing.sv
// Purpose: Integration window sequencing and conversion counting.
// Assumes: osc_tick is a one-cycle pulse at the oscillator rate.
// Notes: light_pulse stands for one converter count from the photodiode.
`timescale 1ns/1ps
`include "lai_consts.svh"
module lai_timing (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic ext_mode,
    input wire logic [1:0] res_sel,
    input wire logic osc_tick,
    input wire logic sync_cmd,
    input wire logic light_pulse,
    output logic conv_done,
    output lai_pkg::lai_word_t result,
    output lai_pkg::lai_word_t timer_count
);
    import lai_pkg::*;

    lai_tstate_t state, next_state;
    logic [16:0] cyc, next_cyc;
    lai_word_t acc, next_acc, acc_inc, next_result, next_timer;
    logic next_done;

    always_comb begin
        acc_inc = (light_pulse && acc != 16'hFFFF) ? 16'(acc + 16'h0001) : acc;
        next_state = state;
        next_cyc = cyc;
        next_acc = acc;
        next_result = result;
        next_timer = timer_count;
        next_done = 1'b0;
        case (state)
            TS_IDLE: begin
                next_cyc = 17'h00000;
                next_acc = 16'h0000;
                if (enable) begin
                    next_state = ext_mode ? TS_WAIT : TS_RUN;
                end
            end
            TS_WAIT: begin
                if (sync_cmd) begin
                    next_state = TS_RUN;
                end
            end
            TS_RUN: begin
                next_acc = acc_inc;
                if (ext_mode) begin
                    if (osc_tick) begin
                        next_cyc = 17'(cyc + 17'h00001);
                    end
                    if (sync_cmd) begin
                        next_done = 1'b1;
                        next_result = acc_inc;
                        next_timer = cyc[15:0];
                        next_cyc = 17'h00000;
                        next_acc = 16'h0000;
                    end
                end else if (osc_tick) begin
                    if (17'(cyc + 17'h00001) == lai_cycles(res_sel)) begin
                        next_done = 1'b1;
                        next_result = lai_clip(acc_inc, res_sel);
                        next_cyc = 17'h00000;
                        next_acc = 16'h0000;
                    end else begin
                        next_cyc = 17'(cyc + 17'h00001);
                    end
                end
            end
            default: next_state = TS_IDLE;
        endcase
        if (!enable) begin
            next_state = TS_IDLE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state <= TS_IDLE;
            cyc <= 17'h00000;
            acc <= 16'h0000;
            result <= `LAI_DATA_RESET;
            timer_count <= `LAI_DATA_RESET;
            conv_done <= 1'b0;
        end else begin
            state <= next_state;
            cyc <= next_cyc;
            acc <= next_acc;
            result <= next_result;
            timer_count <= next_timer;
            conv_done <= next_done;
        end
    end

endmodule // lai_timing

//--- hdl/lai_top.sv
// Purpose: Light sensor digital core with two-wire target port and registers.
// Assumes: scl and sda_in are synchronous to clk_sys and already clean.
// Notes: The oscillator is modelled as a divided enable of clk_sys.
`timescale 1ns/1ps
`include "lai_consts.svh"
module lai_top (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic light_pulse,
    input wire logic ir_pulse,
    output logic powered,
    output logic ir_select,
    output logic [1:0] range_sel,
    output lai_pkg::lai_byte_t cmd_value
);
    import lai_pkg::*;

    localparam int OSC_DIV = `LAI_OSC_DIV;

    lai_bstate_t st, next_st;
    logic [3:0] cnt, next_cnt;
    lai_byte_t shreg, next_shreg, ptr, next_ptr, cmd, next_cmd;
    logic rw, next_rw, drive, next_drive, mack, next_mack;
    logic scl_q, sda_q, scl_rise, scl_fall, start_cond, stop_cond;
    logic sync_pulse, next_sync;
    logic [7:0] div, next_div;
    logic osc_tick;
    logic conv_done;
    lai_word_t result, timer_count, adc_data, next_adc, tim_data, next_tim;
    logic [2:0] mode_bits;
    logic ext_mode, run_en;

    // Read view of a register; the data pair shows the timer or the result.
    function automatic lai_byte_t reg_read(input lai_byte_t p, input lai_byte_t c,
                                           input lai_word_t a, input lai_word_t t);
        lai_word_t w;
        w = (c[`LAI_BIT_EXT:`LAI_BIT_RES_LO] == `LAI_MODE_EXT_TIMER) ? t : a;
        case (p)
            `LAI_OFS_CMD: reg_read = c;
            `LAI_OFS_LSB: reg_read = w[7:0];
            `LAI_OFS_MSB: reg_read = w[15:8];
            default: reg_read = 8'h00;
        endcase
    endfunction

    assign scl_rise = scl && !scl_q;
    assign scl_fall = !scl && scl_q;
    assign start_cond = scl && scl_q && sda_q && !sda_in;
    assign stop_cond = scl && scl_q && !sda_q && sda_in;
    assign mode_bits = cmd[`LAI_BIT_EXT:`LAI_BIT_RES_LO];
    assign ext_mode = cmd[`LAI_BIT_EXT];
    // Reserved codes 110 and 111 hold the converter idle.
    assign run_en = cmd[`LAI_BIT_EN] && !(mode_bits[2] && mode_bits[1]);
    assign osc_tick = (div == 8'(OSC_DIV - 1));
    assign sda_out = 1'b0;
    assign sda_oe_n = !drive;
    assign powered = cmd[`LAI_BIT_EN];
    assign ir_select = cmd[`LAI_BIT_IR];
    assign range_sel = cmd[`LAI_BIT_RANGE_HI:`LAI_BIT_RANGE_LO];
    assign cmd_value = cmd;

    // Oscillator enable runs the same way in every timing mode.
    always_comb begin
        next_div = osc_tick ? 8'h00 : 8'(div + 8'h01);
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            div <= 8'h00;
        end else begin
            div <= next_div;
        end
    end

    lai_timing u_timing (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .enable(run_en),
        .ext_mode(ext_mode),
        .res_sel(cmd[`LAI_BIT_RES_HI:`LAI_BIT_RES_LO]),
        .osc_tick(osc_tick),
        .sync_cmd(sync_pulse),
        .light_pulse(cmd[`LAI_BIT_IR] ? ir_pulse : light_pulse),
        .conv_done(conv_done),
        .result(result),
        .timer_count(timer_count)
    );

    // Bus target, command register and data registers.
    always_comb begin
        next_st = st;
        next_cnt = cnt;
        next_shreg = shreg;
        next_ptr = ptr;
        next_cmd = cmd;
        next_rw = rw;
        next_drive = drive;
        next_mack = mack;
        next_sync = 1'b0;
        next_adc = adc_data;
        next_tim = tim_data;
        if (conv_done) begin
            next_adc = result;
            next_tim = timer_count;
            if (!cmd[`LAI_BIT_CONT]) begin
                next_cmd[`LAI_BIT_EN] = 1'b0;
            end
        end
        if (start_cond) begin
            next_st = BS_ADDR;
            next_cnt = 4'h0;
            next_drive = 1'b0;
        end else if (stop_cond) begin
            next_st = BS_IDLE;
            next_drive = 1'b0;
        end else if (scl_rise) begin
            case (st)
                BS_ADDR, BS_REG, BS_WR: begin
                    next_shreg = {shreg[6:0], sda_in};
                    next_cnt = 4'(cnt + 4'h1);
                end
                BS_RD: next_cnt = 4'(cnt + 4'h1);
                BS_RDACK: next_mack = !sda_in;
                default: next_st = st;
            endcase
        end else if (scl_fall) begin
            case (st)
                BS_ADDR: begin
                    if (cnt == 4'h8) begin
                        if (shreg[7:1] == `LAI_DEV_ADDR) begin
                            next_rw = shreg[0];
                            next_drive = 1'b1;
                            next_st = BS_AACK;
                        end else begin
                            next_st = BS_IDLE;
                        end
                    end
                end
                BS_AACK: begin
                    next_cnt = 4'h0;
                    if (rw) begin
                        next_shreg = reg_read(ptr, cmd, adc_data, tim_data);
                        next_drive = !next_shreg[7];
                        next_st = BS_RD;
                    end else begin
                        next_drive = 1'b0;
                        next_st = BS_REG;
                    end
                end
                BS_REG: begin
                    if (cnt == 4'h8) begin
                        if (shreg[`LAI_BIT_SYNC]) begin
                            next_sync = ext_mode;
                        end else begin
                            next_ptr = shreg;
                        end
                        next_drive = 1'b1;
                        next_st = BS_RACK;
                    end
                end
                BS_WR: begin
                    if (cnt == 4'h8) begin
                        if (ptr == `LAI_OFS_CMD) begin
                            next_cmd = shreg;
                        end
                        next_ptr = 8'(ptr + 8'h01);
                        next_drive = 1'b1;
                        next_st = BS_WACK;
                    end
                end
                BS_RACK, BS_WACK: begin
                    next_drive = 1'b0;
                    next_cnt = 4'h0;
                    next_st = BS_WR;
                end
                BS_RD: begin
                    if (cnt == 4'h8) begin
                        next_drive = 1'b0;
                        next_ptr = 8'(ptr + 8'h01);
                        next_st = BS_RDACK;
                    end else begin
                        next_shreg = {shreg[6:0], 1'b0};
                        next_drive = !shreg[6];
                    end
                end
                BS_RDACK: begin
                    next_cnt = 4'h0;
                    if (mack) begin
                        next_shreg = reg_read(ptr, cmd, adc_data, tim_data);
                        next_drive = !next_shreg[7];
                        next_st = BS_RD;
                    end else begin
                        next_st = BS_IDLE;
                    end
                end
                default: next_st = st;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            st <= BS_IDLE;
            cnt <= 4'h0;
            shreg <= 8'h00;
            ptr <= `LAI_OFS_CMD;
            cmd <= `LAI_CMD_RESET;
            rw <= 1'b0;
            drive <= 1'b0;
            mack <= 1'b0;
            sync_pulse <= 1'b0;
            adc_data <= `LAI_DATA_RESET;
            tim_data <= `LAI_DATA_RESET;
        end else begin
            scl_q <= scl;
            sda_q <= sda_in;
            st <= next_st;
            cnt <= next_cnt;
            shreg <= next_shreg;
            ptr <= next_ptr;
            cmd <= next_cmd;
            rw <= next_rw;
            drive <= next_drive;
            mack <= next_mack;
            sync_pulse <= next_sync;
            adc_data <= next_adc;
            tim_data <= next_tim;
        end
    end

endmodule // lai_top

//--- tb/lai_checker.sv
// Purpose: Port-level assertions for the light sensor readout block.
// Assumes: Bound to the top module; one clock domain.
// Notes: Bus timing assumes each clock phase lasts three or more system clocks.
`timescale 1ns/1ps
`include "lai_consts.svh"
module lai_checker (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic scl,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic powered,
    input wire logic ir_select,
    input wire logic [1:0] range_sel,
    input wire lai_pkg::lai_byte_t cmd_value
);
    import lai_pkg::*;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    a_power_on_bus: assert property ($rose(powered) |-> !sda_oe_n)
        else $error("powered rose without a bus acknowledge");
    a_ir_by_bus: assert property ($changed(ir_select) |-> !sda_oe_n)
        else $error("ir_select changed without a bus acknowledge");
    a_range_by_bus: assert property ($changed(range_sel) |-> !sda_oe_n)
        else $error("range_sel changed without a bus acknowledge");
    a_open_drain: assert property (sda_out == 1'b0)
        else $error("sda_out is not low");
    a_reset_clears: assert property ($rose(rst_n) |-> sda_oe_n && cmd_value == 8'h00)
        else $error("state not cleared by reset");
    a_cmd_by_bus: assert property ($changed(cmd_value[6:0]) |-> ##[0:2] !sda_oe_n)
        else $error("command changed without a bus acknowledge");
    a_cont_stays_on: assert property ($fell(powered) && $past(cmd_value[6])
        |-> ##[0:2] !sda_oe_n)
        else $error("continuous mode powered down without a bus write");
    a_drive_scl_low: assert property (scl && $past(scl) && $past(scl, 2) |-> $stable(sda_oe_n))
        else $error("data driver moved while scl high");
    a_cmd_scl_low: assert property (scl && $past(scl) && $past(scl, 2)
        |-> $stable(cmd_value[6:0]))
        else $error("command moved while scl high");
    c_ack_seen: cover property ($fell(sda_oe_n));
    c_auto_off: cover property ($fell(powered) && !cmd_value[6]);
    c_timer_view: cover property (cmd_value[4:2] == `LAI_MODE_EXT_TIMER);
endmodule // lai_checker
bind lai_top lai_checker u_lai_checker (.clk_sys(clk_sys), .rst_n(rst_n), .scl(scl),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .powered(powered), .ir_select(ir_select),
    .range_sel(range_sel), .cmd_value(cmd_value));

//--- tb/lai_host_model.sv
// Purpose: Two-wire bus host model issuing register writes, reads and sync commands.
// Assumes: The bench forms the wire level from both drivers with a pull-up.
// Notes: Each data bit clock phase lasts four system clocks; the high phase of a start lasts eight.
`timescale 1ns/1ps
module lai_host_model (
    input wire logic clk_sys,
    input wire logic sda_wire,
    output logic scl,
    output logic sda_drv
);
    import lai_pkg::*;
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic hold();
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic bit_io(input logic b, output logic r);
        sda_drv <= b;
        hold();
        scl <= 1'b1;
        hold();
        r = sda_wire;
        scl <= 1'b0;
    endtask
    task automatic start();
        sda_drv <= 1'b1;
        hold();
        scl <= 1'b1;
        hold();
        sda_drv <= 1'b0;
        hold();
        scl <= 1'b0;
    endtask
    task automatic stop();
        sda_drv <= 1'b0;
        hold();
        scl <= 1'b1;
        hold();
        sda_drv <= 1'b1;
        hold();
    endtask
    task automatic tx(input lai_byte_t d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    task automatic rx(input logic last, output lai_byte_t d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(last, r);
    endtask
    // Writes a pointer byte and, when asked, one data byte; a pointer with bit 7 is a sync.
    task automatic wr(input logic [6:0] dev, input lai_byte_t ptr, input lai_byte_t d,
                      input logic with_data, output logic ok);
        logic a1;
        logic a2;
        logic a3;
        a3 = 1'b1;
        start();
        tx({dev, 1'b0}, a1);
        tx(ptr, a2);
        if (with_data) begin
            tx(d, a3);
        end
        stop();
        ok = a1 & a2 & a3;
    endtask
    // Reads one or two bytes from ptr through a repeated start.
    task automatic rd(input lai_byte_t ptr, input int n, output lai_word_t v);
        logic a;
        v = 16'h0000;
        start();
        tx(8'h88, a);
        tx(ptr, a);
        start();
        tx(8'h89, a);
        rx(n == 1, v[7:0]);
        if (n == 2) begin
            rx(1'b1, v[15:8]);
        end
        stop();
    endtask
endmodule // lai_host_model

//--- tb/light_adc_integration_timing_tb.sv
// Purpose: Self-checking bench for the light sensor readout block.
// Assumes: The host model sits on the bus; ambient counts come from light_pulse.
// Notes: Uses the 4-bit internal resolution to keep the run short.
`timescale 1ns/1ps
`include "lai_consts.svh"
module light_adc_integration_timing_tb;
    import lai_pkg::*;
    logic clk_sys, rst_n, light_pulse, ir_pulse, sda_out, sda_oe_n, powered, ir_select;
    logic scl, sda_drv, ok;
    logic [1:0] range_sel;
    lai_byte_t cmd_value, c;
    lai_word_t v;
    wire logic sda_wire;
    int miscompares = 0;
    int tests_run = 0;
    int cyc = 0;
    int t0, dur[3];
    assign sda_wire = sda_drv & (sda_oe_n | sda_out);
    lai_top u_lai_top (.clk_sys(clk_sys), .rst_n(rst_n), .scl(scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .light_pulse(light_pulse), .ir_pulse(ir_pulse),
        .powered(powered), .ir_select(ir_select), .range_sel(range_sel),
        .cmd_value(cmd_value));
    lai_host_model u_lai_host_model (.clk_sys(clk_sys), .sda_wire(sda_wire), .scl(scl),
        .sda_drv(sda_drv));
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string name, input lai_word_t lo, input lai_word_t hi,
                       input lai_word_t got);
        tests_run++;
        if ($isunknown(got) || got < lo || got > hi) begin
            $display("MISMATCH %s expected %h..%h seen %h", name, lo, hi, got);
            miscompares++;
        end
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            miscompares++;
            close_out();
        end
    end
    initial begin
        rst_n = 1'b0;
        light_pulse = 1'b0;
        ir_pulse = 1'b0;
        dur = '{0, 40, 20};
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        u_lai_host_model.rd(`LAI_OFS_LSB, 2, v);
        chk("data_reset", 16'h0000, 16'h0000, v);
        u_lai_host_model.wr(7'h45, `LAI_OFS_CMD, 8'hCC, 1'b1, ok);
        chk("foreign_ack", 16'h0000, 16'h0000, 16'(ok));
        u_lai_host_model.rd(`LAI_OFS_CMD, 1, v);
        chk("cmd_after_foreign", 16'h0000, 16'h0000, v);
        for (int i = 0; i < 8; i++) begin
            c = {2'b01, i[0], i[2:0], i[1:0]};
            u_lai_host_model.wr(`LAI_DEV_ADDR, `LAI_OFS_CMD, c, 1'b1, ok);
            u_lai_host_model.rd(`LAI_OFS_CMD, 1, v);
            chk("cmd_rw", 16'(c), 16'(c), v);
            chk("cmd_pins", 16'({c[5], c[1:0]}), 16'({c[5], c[1:0]}),
                16'({ir_select, range_sel}));
        end
        // Only the infrared input counts here, so a full result proves the source select.
        ir_pulse <= 1'b1;
        u_lai_host_model.wr(`LAI_DEV_ADDR, `LAI_OFS_CMD, 8'hAC, 1'b1, ok);
        t0 = cyc;
        while (powered === 1'b1 && cyc < t0 + 3000) @(posedge clk_sys);
        chk("oneshot_len", 16'(15 * `LAI_OSC_DIV - 40), 16'(16 * `LAI_OSC_DIV + 8),
            16'(cyc - t0));
        u_lai_host_model.rd(`LAI_OFS_CMD, 1, v);
        chk("cmd_auto_off", 16'h002C, 16'h002C, v);
        u_lai_host_model.rd(`LAI_OFS_LSB, 2, v);
        chk("result_ir_4bit", 16'h000F, 16'h000F, v);
        ir_pulse <= 1'b0;
        light_pulse <= 1'b1;
        u_lai_host_model.wr(`LAI_DEV_ADDR, `LAI_OFS_CMD, 8'hD4, 1'b1, ok);
        for (int k = 0; k < 3; k++) begin
            while (cyc < t0 + dur[k] * `LAI_OSC_DIV) @(posedge clk_sys);
            t0 = cyc;
            u_lai_host_model.wr(`LAI_DEV_ADDR, 8'h80, 8'h00, 1'b0, ok);
            if (k > 0) begin
                u_lai_host_model.rd(`LAI_OFS_LSB, 2, v);
                chk("timer", 16'(dur[k] - 1), 16'(dur[k] + 1), v);
                u_lai_host_model.wr(`LAI_DEV_ADDR, `LAI_OFS_CMD, 8'hD0, 1'b1, ok);
                u_lai_host_model.rd(`LAI_OFS_LSB, 2, v);
                chk("ext_result", 16'(dur[k] * `LAI_OSC_DIV - 2),
                    16'(dur[k] * `LAI_OSC_DIV + 2), v);
                u_lai_host_model.wr(`LAI_DEV_ADDR, `LAI_OFS_CMD, 8'hD4, 1'b1, ok);
            end
        end
        u_lai_host_model.wr(`LAI_DEV_ADDR, `LAI_OFS_CMD, 8'h00, 1'b1, ok);
        chk("power_off", 16'h0000, 16'h0000, 16'(powered));
        close_out();
    end
endmodule // light_adc_integration_timing_tb
